//--- hdl/cier_core.sv
`timescale 1ns/100ps
// Contract
// - A port read-modify-write takes its source from the pin levels, not the output latch.
// - A result written to the timer-zero count with destination bit 1 clears the prescaler if assigned.
// - A change of program counter or a true conditional test costs two cycles, the second a no-operation.
// - A second word of a two-word instruction reached alone executes as a no-operation.
// - Every program word decodes to a valid instruction, operand words being harmless.
// - A started table write runs on by itself until its write cycle ends.
module cier_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] instr,
  output logic [11:0] pc,
  input wire logic [7:0] data_rd,
  input wire logic [7:0] port_pins,
  output logic [7:0] data_addr,
  output logic [7:0] data_wr,
  output logic data_we,
  input wire logic prescaler_to_timer,
  output logic prescaler_clear,
  output logic [7:0] work,
  output logic [7:0] status,
  output logic write_busy
);
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_sn;
  // ****************************************
  // Reset release through two flops
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_sn = rst_s2_q;

  cier_data_if tw();
  cier_write_timer u_timer (
    .clock(clock),
    .rst_n(rst_sn),
    .wr(tw)
  );

  cier_pkg::cier_state_t state_q;
  logic [11:0] pc_q;
  logic [7:0] work_q;
  logic [7:0] status_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic we_q;
  logic presc_q;
  logic busy_q;
  logic start_q;

  // ****************************************
  // Decode
  // ****************************************
  logic is_or_lit, is_or_loc, is_copy, is_second, is_bra, is_bcond, is_btest, is_long, is_tblwr;
  logic is_port, cond_true, dest_loc, active;
  logic [7:0] src, or_res;
  // Relative offset; the long form belongs to the unconditional branch
  logic [11:0] rel_off;
  assign active = state_q == cier_pkg::CIER_FETCH;
  assign is_or_lit = instr[15:8] == cier_pkg::OP_OR_LITERAL;
  assign is_or_loc = instr[15:10] == cier_pkg::OP_OR_LOCATION;
  assign is_copy = instr[15:9] == cier_pkg::OP_COPY_WORK;
  assign is_second = instr[15:12] == cier_pkg::OP_SECOND_WORD;
  assign is_bra = instr[15:12] == cier_pkg::OP_BRA;
  assign is_bcond = instr[15:12] == cier_pkg::OP_BRANCH_COND && instr[11:9] != 3'b111;
  assign is_long = instr[15:9] == cier_pkg::OP_LONG_JUMP || instr[15:8] == cier_pkg::OP_LONG_JUMP_B;
  assign is_btest = instr[15:12] == cier_pkg::OP_BIT_TEST_CLR || instr[15:12] == cier_pkg::OP_BIT_TEST_SET;
  assign is_tblwr = instr[15:4] == cier_pkg::OP_TABLE_WRITE && instr[3:2] == cier_pkg::TABLE_WRITE_LO;
  assign dest_loc = instr[9];
  // Port locations read the pins so a read-modify-write sees real levels
  assign is_port = instr[7:0] >= cier_pkg::ADDR_PORT_A && instr[7:0] <= cier_pkg::ADDR_PORT_E;
  assign src = is_port ? port_pins : data_rd;
  assign or_res = work_q | (is_or_lit ? instr[7:0] : src);
  assign rel_off = is_bra ? {instr[10], instr[10:0]} : {{4{instr[7]}}, instr[7:0]};
  // Conditional branch: flag selected by low opcode bits, inverted by bit 8
  always_comb begin
    cond_true = 1'b0;
    if (is_bcond) begin
      case (instr[10:9])
        2'b00: cond_true = status_q[cier_pkg::FLAG_Z] ^ instr[8];
        2'b11: cond_true = status_q[cier_pkg::FLAG_N] ^ instr[8];
        default: cond_true = status_q[0] ^ instr[8];
      endcase
    end else if (is_btest) begin
      cond_true = src[instr[11:9]] ^ (instr[15:12] == cier_pkg::OP_BIT_TEST_CLR);
    end
  end

  // ****************************************
  // Sequencer: taken flow costs a flushed cycle
  // ****************************************
  always_ff @(posedge clock or negedge rst_sn) begin
    if (!rst_sn) begin
      state_q <= cier_pkg::CIER_FETCH;
      pc_q <= cier_pkg::PC_RESET;
    end else begin
      case (state_q)
        cier_pkg::CIER_FETCH: begin
          if (is_bra || is_long || (is_bcond && cond_true)) begin
            pc_q <= is_long ? {instr[3:0], instr[7:0]} : pc_q + 12'h001 + rel_off; // Counts from the next word
            state_q <= cier_pkg::CIER_FLUSH;
          end else if (is_btest && cond_true) begin
            pc_q <= pc_q + 12'h002; // Past the skipped word; the flush cycle stands in for it
            state_q <= cier_pkg::CIER_FLUSH;
          end else begin
            pc_q <= pc_q + 12'h001;
          end
        end
        cier_pkg::CIER_FLUSH: begin
          // Pc holds so the word seen here runs next; advancing would lose the target
          state_q <= cier_pkg::CIER_FETCH;
        end
        default: state_q <= cier_pkg::CIER_FETCH;
      endcase
    end
  end

  // ****************************************
  // Work register and flags
  // ****************************************
  always_ff @(posedge clock or negedge rst_sn) begin
    if (!rst_sn) begin
      work_q <= cier_pkg::WORK_RESET;
      status_q <= 8'h00;
    end else if (active && (is_or_lit || is_or_loc)) begin
      if (is_or_lit || !dest_loc) begin
        work_q <= or_res;
      end
      status_q[cier_pkg::FLAG_N] <= or_res[7];
      status_q[cier_pkg::FLAG_Z] <= or_res == 8'h00;
    end
  end

  // ****************************************
  // Data writes; unknown codes fall through as no-operation
  // ****************************************
  always_ff @(posedge clock or negedge rst_sn) begin
    if (!rst_sn) begin
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
      presc_q <= 1'b0;
    end else begin
      addr_q <= instr[7:0];
      wdata_q <= is_copy ? work_q : or_res;
      // Anything else, second words included, writes nothing
      we_q <= active && !is_second && (is_copy || (is_or_loc && dest_loc));
      presc_q <= active && prescaler_to_timer && instr[7:0] == cier_pkg::ADDR_TIMER_ZERO &&
                 (is_copy || (is_or_loc && dest_loc));
    end
  end

  // Table write start; the timer owns it once begun
  always_ff @(posedge clock or negedge rst_sn) begin
    if (!rst_sn) begin
      start_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      start_q <= active && is_tblwr && !tw.busy;
      busy_q <= tw.busy;
    end
  end
  assign tw.start = start_q;

  assign pc = pc_q;
  assign work = work_q;
  assign status = status_q;
  assign data_addr = addr_q;
  assign data_wr = wdata_q;
  assign data_we = we_q;
  assign prescaler_clear = presc_q;
  assign write_busy = busy_q;

  // ****************************************
  // Checks
  // ****************************************
  a_or_literal_res: assert property (@(posedge clock) disable iff (!rst_sn)
    active && is_or_lit |=> work == ($past(work) | $past(instr[7:0]))) else $error("or literal wrong");
  a_or_flag_zero: assert property (@(posedge clock) disable iff (!rst_sn)
    active && is_or_lit |=> status[cier_pkg::FLAG_Z] == (work == 8'h00)) else $error("zero flag wrong");
  a_branch_two_cyc: assert property (@(posedge clock) disable iff (!rst_sn)
    active && is_bra |=> state_q == cier_pkg::CIER_FLUSH ##1 active) else $error("branch not two cycles");
  a_flush_no_write: assert property (@(posedge clock) disable iff (!rst_sn)
    state_q == cier_pkg::CIER_FLUSH |=> !data_we && work == $past(work)) else $error("flush did work");
  a_second_word_nop: assert property (@(posedge clock) disable iff (!rst_sn)
    is_second |=> !data_we && !prescaler_clear) else $error("second word acted");
  a_unknown_harmless: assert property (@(posedge clock) disable iff (!rst_sn)
    !(is_copy || is_or_loc) |=> !data_we) else $error("stray write");
  a_prescaler_clear: assert property (@(posedge clock) disable iff (!rst_sn)
    active && is_copy && prescaler_to_timer && instr[7:0] == cier_pkg::ADDR_TIMER_ZERO |=> prescaler_clear)
    else $error("prescaler not cleared");
  a_port_from_pins: assert property (@(posedge clock) disable iff (!rst_sn)
    active && is_or_loc && dest_loc && is_port |=> data_wr == ($past(work) | $past(port_pins)))
    else $error("port latch used");
  a_table_runs: assert property (@(posedge clock) disable iff (!rst_sn)
    start_q |=> ##1 write_busy [*8]) else $error("table write cut");
  // Flow and decode details that the bench reaches only indirectly
  a_skip_lands: assert property (@(posedge clock) disable iff (!rst_sn)
    active && is_btest && cond_true |=> state_q == cier_pkg::CIER_FLUSH && pc == $past(pc) + 12'h002)
    else $error("skip landed wrong");
  a_branch_target: assert property (@(posedge clock) disable iff (!rst_sn)
    active && is_bra |=> pc == $past(pc) + 12'h001 + $past(rel_off)) else $error("branch target wrong");
  a_lit_no_write: assert property (@(posedge clock) disable iff (!rst_sn)
    active && is_or_lit |=> !data_we) else $error("literal wrote data");
  a_loc_zero_flag: assert property (@(posedge clock) disable iff (!rst_sn)
    active && is_or_loc |=> status[cier_pkg::FLAG_Z] == ($past(or_res) == 8'h00))
    else $error("location zero flag wrong");
  a_table_refused: assert property (@(posedge clock) disable iff (!rst_sn)
    active && is_tblwr && tw.busy |=> !start_q) else $error("table write restarted");
  c_branch_taken: cover property (@(posedge clock) disable iff (!rst_sn) active && is_bcond && cond_true);
  c_skip_taken: cover property (@(posedge clock) disable iff (!rst_sn) active && is_btest && cond_true);
  c_copy_timer: cover property (@(posedge clock) disable iff (!rst_sn) active && is_copy && prescaler_to_timer);
  c_or_to_loc: cover property (@(posedge clock) disable iff (!rst_sn) active && is_or_loc && dest_loc);
  c_table_write: cover property (@(posedge clock) disable iff (!rst_sn) start_q);
endmodule

//--- hdl/cier_data_if.sv
`timescale 1ns/100ps
// Start and busy handshake from the core to the table write timer
interface cier_data_if;
  logic start;
  logic busy;
  modport core (output start, input busy);
  modport timer (input start, output busy);
endinterface

//--- hdl/cier_pkg.sv
package cier_pkg;
  // ****************************************
  // Widths and encodings
  // ****************************************
  localparam int unsigned DATA_W = 8;
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned ADDR_W = 12;
  // Opcode patterns (upper bits of the instruction word)
  localparam logic [7:0] OP_OR_LITERAL = 8'h09;
  localparam logic [5:0] OP_OR_LOCATION = 6'h04;
  localparam logic [6:0] OP_COPY_WORK = 7'h37;
  localparam logic [3:0] OP_SECOND_WORD = 4'hf;
  localparam logic [3:0] OP_BRA = 4'hd;
  localparam logic [3:0] OP_BRANCH_COND = 4'he;
  localparam logic [3:0] OP_BIT_TEST_CLR = 4'hb;
  localparam logic [3:0] OP_BIT_TEST_SET = 4'ha;
  localparam logic [6:0] OP_LONG_JUMP = 7'h76;
  localparam logic [7:0] OP_LONG_JUMP_B = 8'hef;
  // Table write: upper twelve bits zero, then the two set bits of the 0x000c..0x000f group
  localparam logic [11:0] OP_TABLE_WRITE = 12'h000;
  localparam logic [1:0] TABLE_WRITE_LO = 2'h3;
  // Special data addresses in the access bank
  localparam logic [7:0] ADDR_TIMER_ZERO = 8'hd6;
  localparam logic [7:0] ADDR_PORT_A = 8'h80;
  localparam logic [7:0] ADDR_PORT_E = 8'h84;
  // Reset values and status flag bit positions
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam int unsigned FLAG_N = 4;
  localparam int unsigned FLAG_Z = 2;
  // Self-timed write length, cycles
  localparam int unsigned WRITE_CYCLES = 16;
  // Sequencer states
  typedef enum logic [2:0] {
    CIER_FETCH = 3'b001,
    CIER_FLUSH = 3'b010,
    CIER_SKIP2 = 3'b100
  } cier_state_t;
endpackage

//--- hdl/cier_write_timer.sv
`timescale 1ns/100ps
module cier_write_timer #(
  parameter int unsigned CYCLES = cier_pkg::WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  cier_data_if.timer wr
);
  // The counter is eight bits wide, so longer writes cannot be timed
  if (CYCLES < 1 || CYCLES > 255) begin : g_bad_cycles
    $error("CYCLES out of range");
  end
  logic [7:0] cnt_q;
  // ****************************************
  // Self-timed write; nothing can abort it once started
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end else if (wr.start) begin
      cnt_q <= 8'(CYCLES);
    end
  end
  assign wr.busy = cnt_q != 8'h00;
  a_write_runs_on: assert property (@(posedge clock) disable iff (!rst_n)
    wr.busy && cnt_q != 8'h01 |=> wr.busy) else $error("write stopped early");
endmodule

//--- test/cier_mem_model.sv
`timescale 1ns/100ps
// ****************************************
// Program and data memory facing the core
// ****************************************
module cier_mem_model (
  input wire logic clock,
  input wire logic [11:0] pc,
  output logic [15:0] instr,
  input wire logic [7:0] data_addr,
  input wire logic [7:0] data_wr,
  input wire logic data_we,
  output logic [7:0] data_rd
);
  logic [15:0] prog [0:4095];
  logic [7:0] ram [0:255];
  // Reads are combinational, so the core sees a new word as soon as pc moves
  assign instr = prog[pc];
  assign data_rd = ram[instr[7:0]];
  // A write lands on the edge that sees the pulse, never later
  always @(posedge clock) begin
    if (data_we === 1'b1) begin
      ram[data_addr] <= data_wr;
    end
  end
endmodule

//--- test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] port_pins = 8'h00;
  logic pre_to_tmr = 1'b0;
  logic [15:0] instr;
  logic [11:0] pc;
  logic [7:0] data_rd, data_addr, data_wr, work, status;
  logic data_we, pre_clr, write_busy;
  int err_total = 0;
  int n_tests = 0;
  int cyc, hit, we_cnt, clr_cnt, busy_cnt, base;
  // ****************************************
  // Clock, design and memory
  // ****************************************
  always #2.5 clock = ~clock;
  cier_core u_dut (.clock(clock), .rst_n(rst_n), .instr(instr), .pc(pc), .data_rd(data_rd),
    .port_pins(port_pins), .data_addr(data_addr), .data_wr(data_wr), .data_we(data_we),
    .prescaler_to_timer(pre_to_tmr), .prescaler_clear(pre_clr), .work(work), .status(status),
    .write_busy(write_busy));
  cier_mem_model u_mem (.clock(clock), .pc(pc), .instr(instr), .data_addr(data_addr),
    .data_wr(data_wr), .data_we(data_we), .data_rd(data_rd));
  // Pulses are counted every edge, since they stand for one cycle only
  always @(posedge clock) begin
    if (!rst_n) begin
      cyc <= 0; hit <= 0; we_cnt <= 0; clr_cnt <= 0; busy_cnt <= 0;
    end else begin
      cyc <= cyc + 1;
      if (work !== 8'h00 && hit == 0) hit <= cyc;
      if (data_we === 1'b1) we_cnt <= we_cnt + 1;
      if (pre_clr === 1'b1) clr_cnt <= clr_cnt + 1;
      if (write_busy === 1'b1) busy_cnt <= busy_cnt + 1;
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic load(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2);
    for (int i = 0; i < 4096; i++) u_mem.prog[i] = 16'h0000;
    for (int i = 0; i < 256; i++) u_mem.ram[i] = 8'h00;
    u_mem.prog[0] = w0; u_mem.prog[1] = w1; u_mem.prog[2] = w2;
  endtask
  // Fresh reset for every program, so no state leaks between scenarios
  task automatic run(input int n);
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_or();
    load(16'h0900, 16'h0000, 16'h0000); run(8);
    check("zero flag", 8'(status[cier_pkg::FLAG_Z]), 8'h01);
    load(16'h099a, 16'h0935, 16'h0000); run(8);
    check("work", work, 8'hbf);
    check("neg flag", 8'(status[cier_pkg::FLAG_N]), 8'h01);
    check("zero flag", 8'(status[cier_pkg::FLAG_Z]), 8'h00);
  endtask
  task automatic t_loc();
    load(16'h0991, 16'h1020, 16'h0000); u_mem.ram[8'h20] = 8'h13; run(10);
    check("work", work, 8'h93);
    check("writes", 8'(we_cnt), 8'h00);
    load(16'h0991, 16'h1220, 16'h0000); u_mem.ram[8'h20] = 8'h13; run(10);
    check("location", u_mem.ram[8'h20], 8'h93);
    check("work", work, 8'h91);
  endtask
  // Latch holds ones but the upper four pins read low; the pins must win
  task automatic t_port();
    load(16'h0910, 16'h1280, 16'h0000); u_mem.ram[8'h80] = 8'hff; port_pins = 8'h0f; run(10);
    check("port", u_mem.ram[8'h80], 8'h1f);
    port_pins = 8'h00;
  endtask
  task automatic t_timer();
    logic [1:0] cases [3] = '{2'b11, 2'b01, 2'b10};
    for (int i = 0; i < 3; i++) begin
      load(16'h0901, cases[i][1] ? 16'h12d6 : 16'h10d6, 16'h0000); pre_to_tmr = cases[i][0]; run(10);
      check("clears", 8'(clr_cnt), 8'(cases[i][1] & cases[i][0]));
    end
    // A plain copy into the count register clears the prescaler as well
    load(16'h0955, 16'h6ed6, 16'h0000);
    pre_to_tmr = 1'b1;
    run(10);
    check("copy clears", 8'(clr_cnt), 8'h01);
    check("copied count", u_mem.ram[8'hd6], 8'h55);
    pre_to_tmr = 1'b0;
  endtask
  // Cost is measured against a plain one-cycle instruction in the same slot
  task automatic t_branch();
    load(16'h0000, 16'h0901, 16'h0000); run(10); base = hit;
    // Branch by one over a word that would spoil work; eight edges leave pc at word 8
    load(16'hd001, 16'h09ff, 16'h0901);
    run(10);
    check("branch delay", 8'(hit - base), 8'h01);
    check("branch target", work, 8'h01);
    check("branch pc", 8'(pc), 8'h08);
    load(16'hb030, 16'h09ff, 16'h0901); run(10);
    check("skip delay", 8'(hit - base), 8'h01);
    check("work", work, 8'h01);
    // Zero flag from the first word; a true test adds its flush to the later slot
    load(16'h0900, 16'he000, 16'h0901);
    run(10);
    check("taken test delay", 8'(hit - base), 8'h02);
    load(16'h0900, 16'he100, 16'h0901);
    run(10);
    check("false test delay", 8'(hit - base), 8'h01);
  endtask
  task automatic t_second();
    load(16'hf123, 16'h0902, 16'hffff); u_mem.ram[8'h23] = 8'h40; run(10);
    check("work", work, 8'h02);
    check("writes", 8'(we_cnt), 8'h00);
    check("neg flag", 8'(status[cier_pkg::FLAG_N]), 8'h00);
  endtask
  // Second start lands while busy and must not stretch the write
  task automatic t_table();
    int n;
    load(16'h000c, 16'h0905, 16'h000c); run(4);
    n = 0;
    while (!(busy_cnt > 0 && write_busy === 1'b0) && n < 80) begin
      @(posedge clock);
      #1 n++;
    end
    if (n == 80) begin
      err_total++;
      end_of_test();
    end else begin
      check("busy cycles", 8'(busy_cnt), 8'(cier_pkg::WRITE_CYCLES));
      check("work", work, 8'h05);
    end
  endtask
  initial begin
    t_or(); t_loc(); t_port(); t_timer(); t_branch(); t_second(); t_table();
    end_of_test();
  end
endmodule
